//--- bench/prog_tool.sv
// Programming tool model: APB master that writes the option bytes.
// Assumes the slave answers with pready_i on the rising edge of clk_i.
`timescale 1ns/1ps
module prog_tool
    import option_cfg_pkg::*;
(
    input wire logic clk_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [option_cfg_pkg::ADDR_W-1:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err, output bit hung);
        int n;
        logic [31:0] d;
        d = wd;
        // A real tool never clears reserved positions
        if (wr && addr == OFF_OPT0) begin
            d[7:0] = d[7:0] | 8'h26;
        end
        // Doubler only with resonator in the 2-4 MHz range
        if (wr && addr == OFF_OPT1 && d[5:1] != 5'h01) begin
            d[0] = 1'b1;
        end
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 40);
        rd = prdata_i;
        err = pslverr_i;
        hung = (pready_i !== 1'b1);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : prog_tool

//--- bench/tb.sv
// Self-checking bench of the option byte loader.
// Assumes the tool model on APB; program memory erase answered here.
`timescale 1ns/1ps
module tb;
    import option_cfg_pkg::*;
    typedef struct packed {
        logic [7:0] opt0;
        logic [7:0] opt1;
        logic [11:0] cfg;
    } row_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic prog_pin = 1'b0;
    logic core_req = 1'b0;
    logic halt_in = 1'b0;
    logic halt_exit = 1'b0;
    logic wdg_run = 1'b0;
    logic erase_done = 1'b0;
    logic mem_erase, reset_active, halt_reset, wdg_hw, low_det, warn_det;
    logic m_wdg, m_pll;
    logic [1:0] m_osc;
    logic [2:0] m_range;
    logic protect, pll, err, seen;
    logic [1:0] level, osc;
    logic [2:0] range;
    logic [11:0] cfg, prev;
    int bad_count = 0;
    int checked = 0;
    int erase_count = 0;
    int erase_wait = 0;
    int cnt, n0, len;
    // Field order: wdg_hw low_det warn_det level protect osc range pll
    row_type rows [4] = '{
        '{8'h7f, 8'h01, 12'b0_0_0_11_0_00_000_0},
        '{8'hb7, 8'h42, 12'b1_1_1_10_0_00_001_1},
        '{8'hef, 8'h56, 12'b0_1_1_01_0_01_011_0},
        '{8'he6, 8'h74, 12'b0_1_1_00_1_11_010_0}};

    assign cfg = {wdg_hw, low_det, warn_det, level, protect, osc, range, pll};
    always #25 clk_i = ~clk_i;

    prog_tool tool (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

    option_byte_config uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .prog_mode_pin_i(prog_pin), .core_reset_req_i(core_req),
        .halt_enter_i(halt_in), .halt_exit_i(halt_exit),
        .watchdog_run_i(wdg_run), .mem_erase_done_i(erase_done),
        .mem_erase_o(mem_erase), .reset_active_o(reset_active),
        .halt_reset_o(halt_reset), .watchdog_hw_enable_o(wdg_hw),
        .low_supply_reset_detector_o(low_det),
        .supply_warning_detector_o(warn_det), .voltage_detect_level_o(level),
        .readout_protect_o(protect), .osc_source_type_o(osc),
        .osc_freq_range_o(range), .pll_enable_o(pll));

    // Mask coded part on the same bus: programming must never reach it
    option_byte_config #(.MASK_ROM(1'b1), .MASK_OPT0(8'hb7),
        .MASK_OPT1(8'h42)) uut_mask (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(), .pready_o(), .pslverr_o(),
        .prog_mode_pin_i(prog_pin), .core_reset_req_i(core_req),
        .halt_enter_i(1'b0), .halt_exit_i(1'b0),
        .watchdog_run_i(1'b0), .mem_erase_done_i(1'b0),
        .mem_erase_o(), .reset_active_o(), .halt_reset_o(),
        .watchdog_hw_enable_o(m_wdg), .low_supply_reset_detector_o(),
        .supply_warning_detector_o(), .voltage_detect_level_o(),
        .readout_protect_o(), .osc_source_type_o(m_osc),
        .osc_freq_range_o(m_range), .pll_enable_o(m_pll));

    // Program memory wipe takes a few cycles, then reports done
    always @(posedge clk_i) begin
        erase_done <= (erase_wait == 1);
        if (erase_wait > 0) begin
            erase_wait <= erase_wait - 1;
        end
        if (mem_erase === 1'b1) begin
            erase_count <= erase_count + 1;
            erase_wait <= 6;
        end
    end

    task automatic close_out();
        $display("Counts: %0d checked, %0d mismatched", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen_v,
            input logic [31:0] exp);
        checked++;
        if (seen_v !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd);
        bit hung;
        tool.xfer(wr, addr, wd, rd, err, hung);
        if (hung) begin
            bad_count++;
            close_out();
        end
    endtask : bus

    task automatic phase(output int c);
        c = 0;
        while (reset_active === 1'b1 && c < 5000) begin
            @(posedge clk_i);
            c++;
        end
        if (c >= 5000) begin
            bad_count++;
            close_out();
        end
    endtask : phase

    task automatic wait_rise();
        int n;
        n = 0;
        while (reset_active !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        if (reset_active !== 1'b1) begin
            bad_count++;
            close_out();
        end
    endtask : wait_rise

    task automatic erase();
        int n;
        n0 = erase_count;
        bus(1'b1, OFF_CMD, 32'h1 << CMD_ERASE);
        n = 0;
        do begin
            bus(1'b0, OFF_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY] === 1'b1 && n < 200);
        if (rd[STAT_BUSY] !== 1'b0) begin
            bad_count++;
            close_out();
        end
        bus(1'b0, OFF_OPT0, 32'h0);
    endtask : erase

    initial begin
        repeat (20) @(posedge clk_i);
        check("active in reset", reset_active, 1);
        rst_i <= 1'b0;
        @(posedge clk_i);
        phase(cnt);
        check("ship cfg", cfg, 12'b0_1_1_00_0_10_111_0);
        check("ship phase", cnt >= 255 && cnt <= 259, 1);
        bus(1'b0, OFF_OPT0, 32'h0);
        check("closed opt0", err, 1);
        bus(1'b1, OFF_CMD, 32'h1);
        check("closed cmd", err, 1);
        bus(1'b0, OFF_STAT, 32'h0);
        check("stat closed", {err, rd[STAT_PROG]}, 0);
        $display("test closed access done");
        prog_pin <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus(1'b0, OFF_STAT, 32'h0);
        check("stat open", rd[STAT_PROG], 1);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", err, 1);
        bus(1'b1, OFF_STAT, 32'h0);
        check("stat write", err, 1);
        bus(1'b0, OFF_OPT0, 32'h0);
        check("ship opt0", rd, 32'he7);
        bus(1'b0, OFF_OPT1, 32'h0);
        check("ship opt1", rd, 32'hef);
        prev = 12'b0_1_1_00_0_10_111_0;
        foreach (rows[i]) begin
            erase();
            check("blank opt0", rd, 32'hff);
            check("no wipe", erase_count - n0, 0);
            bus(1'b1, OFF_OPT0, {24'h0, rows[i].opt0});
            bus(1'b1, OFF_OPT1, {24'h0, rows[i].opt1});
            check("cfg held", cfg, prev);
            core_req <= 1'b1;
            @(posedge clk_i);
            core_req <= 1'b0;
            wait_rise();
            phase(cnt);
            len = rows[i].opt1[6] ? 256 : 4096;
            check("cfg", cfg, rows[i].cfg);
            check("phase", len <= cnt + 1 && cnt <= len + 2, 1);
            wdg_run <= 1'b1;
            halt_in <= 1'b1;
            @(posedge clk_i);
            halt_in <= 1'b0;
            seen = 1'b0;
            repeat (3) begin
                @(posedge clk_i);
                seen = seen | (halt_reset === 1'b1);
            end
            check("halt reset", seen, rows[i].opt0[7]);
            wdg_run <= 1'b0;
            repeat (3) @(posedge clk_i);
            phase(cnt);
            prev = rows[i].cfg;
            $display("test row %0d done", i);
        end
        // Protected part: wipe of program memory must come first
        erase();
        check("wipe", erase_count - n0, 1);
        check("blank after wipe", rd, 32'hff);
        halt_exit <= 1'b1;
        @(posedge clk_i);
        halt_exit <= 1'b0;
        wait_rise();
        phase(cnt);
        check("halt exit", cnt >= 255 && cnt <= 258, 1);
        check("no relatch", cfg, prev);
        check("mask cfg", {m_wdg, m_osc, m_range, m_pll}, 7'b1_00_001_1);
        $display("test protected erase done");
        close_out();
    end
endmodule : tb

//--- logic/nv_if.sv
// Link between the bus front end and the option byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface nv_if;
    logic prog_req;
    logic erase_req;
    logic byte_sel;
    logic [7:0] wdata;
    logic busy;
    logic [7:0] opt0;
    logic [7:0] opt1;
    modport store (
        input prog_req, erase_req, byte_sel, wdata,
        output busy, opt0, opt1
    );
    modport ctrl (
        output prog_req, erase_req, byte_sel, wdata,
        input busy, opt0, opt1
    );
endinterface : nv_if

//--- logic/option_byte_config.sv
// Option byte configuration loader: store, APB access in programming
// mode, reset-time sampling and decode of the hardware configuration.
// Assumes APB master on clk_i; prog_mode_pin_i comes from a device pin.
//
// Function
// - option bytes reachable only in programming mode, never otherwise
// - blank option bytes read all ones
// - byte0 bit7 set forces reset on halt entry with watchdog running
// - byte0 bit6 clear makes watchdog always on; set leaves it to software
// - byte0 bits4:3 pick detector threshold; 11 turns detectors off
// - byte0 bit0 clear enables read-out and write protection
// - erasing options while protected first erases all program memory
// - mask coded parts keep fixed options, programming has no effect
// - user parts ship set to the internal RC clock
// - byte1 bit6 picks 4096 or 256 cycle reset phase, also halt exit
// - byte1 bits5:4 select main clock source
// - byte1 bits3:1 select oscillator frequency range
`timescale 1ns/1ps
module option_byte_config #(
    parameter bit MASK_ROM = 1'b0,
    parameter logic [7:0] MASK_OPT0 = option_cfg_pkg::SHIP_OPT0,
    parameter logic [7:0] MASK_OPT1 = option_cfg_pkg::SHIP_OPT1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [option_cfg_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic prog_mode_pin_i,
    input wire logic core_reset_req_i,
    input wire logic halt_enter_i,
    input wire logic halt_exit_i,
    input wire logic watchdog_run_i,
    input wire logic mem_erase_done_i,
    output logic mem_erase_o,
    output logic reset_active_o,
    output logic halt_reset_o,
    output logic watchdog_hw_enable_o,
    output logic low_supply_reset_detector_o,
    output logic supply_warning_detector_o,
    output logic [1:0] voltage_detect_level_o,
    output logic readout_protect_o,
    output logic [1:0] osc_source_type_o,
    output logic [2:0] osc_freq_range_o,
    output logic pll_enable_o
);
    import option_cfg_pkg::*;

    nv_if nv ();

    logic prog_meta;
    logic prog_mode;
    logic [7:0] opt0_q;
    logic [7:0] opt1_q;
    logic start_pend;
    logic latch;
    logic phase_start;
    logic phase_short;
    logic access_req;
    logic do_xfer;
    logic is_opt;
    logic mapped;
    logic req_err;
    logic [31:0] read_word;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Pin crossing; only the second stage is read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prog_meta <= 1'b0;
            prog_mode <= 1'b0;
        end else if (ce_i) begin
            prog_meta <= prog_mode_pin_i;
            prog_mode <= prog_meta;
        end
    end

    // APB decode
    assign access_req = psel_i && penable_i && !pready_o;
    assign do_xfer = psel_i && penable_i && pready_o;
    assign is_opt = (paddr_i == OFF_OPT0) || (paddr_i == OFF_OPT1);
    assign mapped = is_opt || (paddr_i == OFF_CMD) || (paddr_i == OFF_STAT);

    always_comb begin
        req_err = !mapped;
        if (mapped && paddr_i != OFF_STAT && !prog_mode) begin
            req_err = 1'b1;
        end
        if (pwrite_i && (paddr_i == OFF_STAT || nv.busy)) begin
            req_err = 1'b1;
        end
    end

    always_comb begin
        read_word = '0;
        if (!req_err) begin
            unique case (paddr_i)
                OFF_OPT0: read_word = {24'h000000, nv.opt0};
                OFF_OPT1: read_word = {24'h000000, nv.opt1};
                OFF_STAT: begin
                    read_word[STAT_BUSY] = nv.busy;
                    read_word[STAT_PROTECT] = readout_protect_o;
                    read_word[STAT_MASK] = MASK_ROM;
                    read_word[STAT_RESET] = reset_active_o;
                    read_word[STAT_PROG] = prog_mode;
                end
                default: read_word = '0;
            endcase
        end
    end

    // One wait state: answer is prepared in the first access cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else if (ce_i) begin
            if (access_req) begin
                pready_o <= 1'b1;
                pslverr_o <= req_err;
                prdata_o <= pwrite_i ? 32'h00000000 : read_word;
            end else begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Writes take effect at the edge where pready is sampled high
    assign nv.prog_req = do_xfer && pwrite_i && !pslverr_o && is_opt;
    assign nv.byte_sel = (paddr_i == OFF_OPT1);
    assign nv.wdata = pwdata_i[7:0];
    assign nv.erase_req = do_xfer && pwrite_i && !pslverr_o
        && (paddr_i == OFF_CMD) && pwdata_i[CMD_ERASE];

    option_nv_store #(
        .MASK_ROM(MASK_ROM),
        .MASK_OPT0(MASK_OPT0),
        .MASK_OPT1(MASK_OPT1)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .mem_erase_done_i(mem_erase_done_i),
        .mem_erase_o(mem_erase_o),
        .nv(nv.store)
    );

    // Halt entry reset when the watchdog runs and the option asks for it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            halt_reset_o <= 1'b0;
        end else if (ce_i) begin
            halt_reset_o <= halt_enter_i && watchdog_run_i
                && opt0_q[B0_HALT_RST];
        end
    end

    // Sampling waits out a store operation so a half-erased byte is never
    // taken as configuration
    assign latch = start_pend && !nv.busy;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_pend <= 1'b1;
        end else if (ce_i) begin
            if (core_reset_req_i || halt_reset_o) begin
                start_pend <= 1'b1;
            end else if (latch) begin
                start_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            opt0_q <= SHIP_OPT0;
            opt1_q <= SHIP_OPT1;
        end else if (ce_i && latch) begin
            opt0_q <= nv.opt0;
            opt1_q <= nv.opt1;
        end
    end

    assign phase_start = latch || halt_exit_i;
    assign phase_short = latch ? nv.opt1[B1_RST_CYC] : opt1_q[B1_RST_CYC];

    reset_phase_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(phase_start),
        .short_i(phase_short),
        .active_o(reset_active_o)
    );

    // Decode; reserved bits 5, 2 and 1 of byte 0 and bit 7 of byte 1 unused
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_hw_enable_o <= 1'b0;
            low_supply_reset_detector_o <= 1'b0;
            supply_warning_detector_o <= 1'b0;
            voltage_detect_level_o <= LEVEL_OFF;
            readout_protect_o <= 1'b0;
            osc_source_type_o <= 2'h2;
            osc_freq_range_o <= 3'h7;
            pll_enable_o <= 1'b0;
        end else if (ce_i) begin
            watchdog_hw_enable_o <= !opt0_q[B0_WDG_TYPE];
            low_supply_reset_detector_o <=
                opt0_q[B0_LEVEL_HI:B0_LEVEL_LO] != LEVEL_OFF;
            supply_warning_detector_o <=
                opt0_q[B0_LEVEL_HI:B0_LEVEL_LO] != LEVEL_OFF;
            voltage_detect_level_o <=
                opt0_q[B0_LEVEL_HI:B0_LEVEL_LO];
            readout_protect_o <= !opt0_q[B0_PROTECT];
            osc_source_type_o <= opt1_q[B1_OSC_HI:B1_OSC_LO];
            osc_freq_range_o <= opt1_q[B1_RANGE_HI:B1_RANGE_LO];
            pll_enable_o <= !opt1_q[B1_PLL_OFF];
        end
    end

    chk_hidden_outside_prog: assert property (
        ce_i && access_req && !prog_mode && paddr_i != OFF_STAT
        |=> pslverr_o && pready_o && prdata_o == 32'h00000000)
        else $error("option access answered outside programming mode");

    chk_halt_reset: assert property (
        ce_i |=> halt_reset_o == $past(halt_enter_i && watchdog_run_i
            && opt0_q[B0_HALT_RST]))
        else $error("halt entry reset does not follow option bit");

    chk_wdg_type: assert property (
        ce_i |=> watchdog_hw_enable_o == !$past(opt0_q[B0_WDG_TYPE]))
        else $error("watchdog type decode wrong");

    chk_detector_off: assert property (
        ce_i && opt0_q[B0_LEVEL_HI:B0_LEVEL_LO] == 2'h3
        |=> !low_supply_reset_detector_o && !supply_warning_detector_o)
        else $error("detectors on with level code 11");

    chk_protect_out: assert property (
        ce_i |=> readout_protect_o == !$past(opt0_q[B0_PROTECT]))
        else $error("read-out protection does not follow option bit");

    chk_osc_fields: assert property (
        ce_i |=> osc_source_type_o == $past(opt1_q[5:4])
            && osc_freq_range_o == $past(opt1_q[3:1]))
        else $error("oscillator fields decoded wrong");

    chk_cfg_hold: assert property (
        !(ce_i && latch) |=> $stable(opt0_q) && $stable(opt1_q))
        else $error("configuration changed without a reset");

    chk_ship_default: assert property (
        !MASK_ROM && $past(rst_i) |-> opt1_q[5:4] == 2'h2
            && nv.opt1[5:4] == 2'h2)
        else $error("user part not shipped on internal RC clock");
endmodule : option_byte_config

//--- logic/option_cfg_pkg.sv
// Constants, field layout and types of the option byte configuration.
// Assumes a single 20 MHz clock domain and a 32-bit register bus.
package option_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_OPT0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OPT1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
    localparam int CMD_ERASE = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PROTECT = 1;
    localparam int STAT_MASK = 2;
    localparam int STAT_RESET = 3;
    localparam int STAT_PROG = 4;
    // Option byte 0 fields
    localparam int B0_HALT_RST = 7;
    localparam int B0_WDG_TYPE = 6;
    localparam int B0_LEVEL_HI = 4;
    localparam int B0_LEVEL_LO = 3;
    localparam int B0_PROTECT = 0;
    // Option byte 1 fields
    localparam int B1_RST_CYC = 6;
    localparam int B1_OSC_HI = 5;
    localparam int B1_OSC_LO = 4;
    localparam int B1_RANGE_HI = 3;
    localparam int B1_RANGE_LO = 1;
    localparam int B1_PLL_OFF = 0;
    localparam logic [1:0] LEVEL_OFF = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] SHIP_OPT0 = 8'he7;
    localparam logic [7:0] SHIP_OPT1 = 8'hef;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] RESET_LONG = 13'h1000;
    localparam logic [CNT_W-1:0] RESET_SHORT = 13'h0100;

    typedef enum logic [2:0] {
        STORE_IDLE = 3'h1,
        STORE_WIPE = 3'h2,
        STORE_CLEAR = 3'h4
    } store_state_type;

    function automatic logic [CNT_W-1:0] phase_length(input logic short_sel);
        phase_length = short_sel ? RESET_SHORT : RESET_LONG;
    endfunction : phase_length
endpackage : option_cfg_pkg

//--- logic/option_nv_store.sv
// Non-volatile option byte store with program and erase sequencing.
// Assumes program memory erase logic on the same clock answers done.
`timescale 1ns/1ps
module option_nv_store #(
    parameter bit MASK_ROM = 1'b0,
    parameter logic [7:0] MASK_OPT0 = option_cfg_pkg::SHIP_OPT0,
    parameter logic [7:0] MASK_OPT1 = option_cfg_pkg::SHIP_OPT1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic mem_erase_done_i,
    output logic mem_erase_o,
    nv_if.store nv
);
    import option_cfg_pkg::*;

    store_state_type state;
    logic [7:0] opt_mem [2];
    logic protected_now;

    assign protected_now = !opt_mem[0][B0_PROTECT];
    assign nv.busy = (state != STORE_IDLE);
    assign nv.opt0 = opt_mem[0];
    assign nv.opt1 = opt_mem[1];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= STORE_IDLE;
        end else if (ce_i) begin
            unique case (state)
                STORE_IDLE: begin
                    if (nv.erase_req && !MASK_ROM) begin
                        state <= protected_now ? STORE_WIPE
                            : STORE_CLEAR;
                    end
                end
                STORE_WIPE: begin
                    if (mem_erase_done_i) begin
                        state <= STORE_CLEAR;
                    end
                end
                STORE_CLEAR: begin
                    state <= STORE_IDLE;
                end
            endcase
        end
    end

    // Program memory wipe request, one pulse per protected erase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_erase_o <= 1'b0;
        end else if (ce_i) begin
            mem_erase_o <= (state == STORE_IDLE) && nv.erase_req && !MASK_ROM
                && protected_now;
        end
    end

    // Programming only clears bits; only an erase, or rst_i reloading the ship values, sets them again
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            opt_mem[0] <= MASK_ROM ? MASK_OPT0 : SHIP_OPT0;
            opt_mem[1] <= MASK_ROM ? MASK_OPT1 : SHIP_OPT1;
        end else if (ce_i && !MASK_ROM) begin
            if (state == STORE_CLEAR) begin
                opt_mem[0] <= ERASED_BYTE;
                opt_mem[1] <= ERASED_BYTE;
            end else if (nv.prog_req && state == STORE_IDLE) begin
                opt_mem[nv.byte_sel] <= opt_mem[nv.byte_sel] & nv.wdata;
            end
        end
    end

    sequence s_protected_erase;
        ce_i && state == STORE_IDLE && nv.erase_req && protected_now;
    endsequence

    chk_wipe_before_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s_protected_erase and !MASK_ROM) |=> mem_erase_o
            && state == STORE_WIPE && opt_mem[0] == $past(opt_mem[0]))
        else $error("protected erase did not wipe program memory first");

    chk_erased_ones: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && state == STORE_CLEAR |=> opt_mem[0] == ERASED_BYTE
            && opt_mem[1] == ERASED_BYTE)
        else $error("erased option bytes are not all ones");

    chk_mask_fixed: assert property (
        @(posedge clk_i) disable iff (rst_i)
        MASK_ROM |-> opt_mem[0] == MASK_OPT0 && opt_mem[1] == MASK_OPT1
            && state == STORE_IDLE)
        else $error("mask coded options changed");
endmodule : option_nv_store

//--- logic/reset_phase_timer.sv
// Counts the reset phase length in CPU cycles.
// Assumes start_i is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module reset_phase_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic short_i,
    output logic active_o
);
    import option_cfg_pkg::*;

    logic [CNT_W-1:0] count;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (ce_i) begin
            if (start_i) begin
                count <= phase_length(short_i);
            end else if (count != '0) begin
                count <= count - 13'h0001;
            end
        end
    end

    // Held high through power-on reset until the first phase ends
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= 1'b1;
        end else if (ce_i) begin
            if (start_i) begin
                active_o <= 1'b1;
            end else if (count == 13'h0001) begin
                active_o <= 1'b0;
            end
        end
    end

    chk_phase_len: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && start_i |=> count == (short_i ? 13'h0100 : 13'h1000)
            && active_o)
        else $error("reset phase loaded with wrong length");
endmodule : reset_phase_timer
